// ===== inc/gpm_defines.vh
// constants for the pin 5 output multiplexer: offsets, fields, resets, codes
// assumes inclusion by bare name from design and bench files
`ifndef GPM_DEFINES_VH
`define GPM_DEFINES_VH

// register indices; byte address is four times the index
`define GPM_CTRL_INDEX      8'h15
`define GPM_CTRL_ADDR       8'h54
`define GPM_MODE_ADDR       8'h80
`define GPM_STAT_ADDR       8'h84

// control register fields
`define GPM_EN_BIT          0
`define GPM_VAL_BIT         1
`define GPM_SRC_LSB         2
`define GPM_SRC_MSB         4
`define GPM_SEL_LSB         5
`define GPM_SEL_MSB         7
`define GPM_CTRL_RESET      8'h00
`define GPM_MODE_RESET      1'b0

// source codes
`define GPM_SRC_STATUS      3'h4
`define GPM_SRC_RSVD        3'h5

// device status signal codes
`define GPM_DEV_LOCK_OR     3'h0
`define GPM_DEV_LOCK_AND    3'h1
`define GPM_DEV_PASS_AND    3'h2
`define GPM_DEV_FSYNC       3'h3

// transmit port signal codes
`define GPM_TX_PASS_AND     3'h0
`define GPM_TX_PASS_OR      3'h1
`define GPM_TX_FV           3'h2
`define GPM_TX_LV           3'h3
`define GPM_TX_SYNC         3'h4
`define GPM_TX_INTR         3'h5

// bus responses
`define GPM_RESP_OKAY       2'h0
`define GPM_RESP_SLVERR     2'h2

`endif

// ===== hw/gpm_pin5_output_mux.v
// pin 5 output multiplexer: control register behind an AXI4-Lite slave,
// source and signal selection, and the pin driver with active-low enable.
// assumes all status inputs come from logic on clk_sys_in (no synchronisers).
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "gpm_defines.vh"

module gpm_pin5_output_mux #(
  parameter NUM_RX = 4,
  parameter NUM_TX = 2
) (
  input  wire                  clk_sys_in,
  input  wire                  srst_in,
  // axi4-lite slave
  input  wire [7:0]            s_axi_awaddr_in,
  input  wire                  s_axi_awvalid_in,
  output wire                  s_axi_awready_out,
  input  wire [31:0]           s_axi_wdata_in,
  input  wire [3:0]            s_axi_wstrb_in,
  input  wire                  s_axi_wvalid_in,
  output wire                  s_axi_wready_out,
  output wire [1:0]            s_axi_bresp_out,
  output wire                  s_axi_bvalid_out,
  input  wire                  s_axi_bready_in,
  input  wire [7:0]            s_axi_araddr_in,
  input  wire                  s_axi_arvalid_in,
  output wire                  s_axi_arready_out,
  output wire [31:0]           s_axi_rdata_out,
  output wire [1:0]            s_axi_rresp_out,
  output wire                  s_axi_rvalid_out,
  input  wire                  s_axi_rready_in,
  // receive port indications
  input  wire [4*NUM_RX-1:0]   rx_remote_gpio_in,
  input  wire [NUM_RX-1:0]     rx_lock_in,
  input  wire [NUM_RX-1:0]     rx_pass_in,
  input  wire [NUM_RX-1:0]     rx_frame_valid_in,
  input  wire [NUM_RX-1:0]     rx_line_valid_in,
  input  wire [NUM_RX-1:0]     rx_port_enable_in,
  input  wire                  frame_sync_signal_in,
  // transmit port indications
  input  wire [NUM_TX*NUM_RX-1:0] tx_rx_map_in,
  input  wire [NUM_TX-1:0]     tx_frame_valid_in,
  input  wire [NUM_TX-1:0]     tx_line_valid_in,
  input  wire [NUM_TX-1:0]     tx_synced_in,
  input  wire [NUM_TX-1:0]     tx_interrupt_in,
  // pin
  output wire                  pin5_out,
  output wire                  pin5_oe_n_out
);

  // register state
  reg  [7:0]  ctrl_q;
  reg         local_mode_q;
  reg         aw_got_q;
  reg  [7:0]  aw_addr_q;
  reg         w_got_q;
  reg  [31:0] w_data_q;
  reg         w_strb0_q;
  reg         bvalid_q;
  reg  [1:0]  bresp_q;
  reg         rvalid_q;
  reg  [31:0] rdata_q;
  reg  [1:0]  rresp_q;
  reg         pin_q;
  reg         oe_n_q;

  wire [2:0]  src_sel = ctrl_q[`GPM_SRC_MSB:`GPM_SRC_LSB];
  wire [2:0]  sig_sel = ctrl_q[`GPM_SEL_MSB:`GPM_SEL_LSB];
  wire [NUM_RX-1:0] rx_bit;
  wire [NUM_TX-1:0] tx_bit;
  reg         dev_bit;
  reg         mux_bit;

  // per receive port signal pick
  genvar p;
  generate
    for (p = 0; p < NUM_RX; p = p + 1) begin : g_rx
      wire [7:0] sigs = {rx_line_valid_in[p], rx_frame_valid_in[p], rx_pass_in[p],
                         rx_lock_in[p], rx_remote_gpio_in[4*p+3:4*p]};
      assign rx_bit[p] = sigs[sig_sel];
    end
  endgenerate

  // per transmit port signal pick
  genvar t;
  generate
    for (t = 0; t < NUM_TX; t = t + 1) begin : g_tx
      wire [NUM_RX-1:0] map = tx_rx_map_in[NUM_RX*t+NUM_RX-1:NUM_RX*t];
      reg b;
      always @* begin
        case (sig_sel)
          `GPM_TX_PASS_AND: b = &(rx_pass_in | ~map);
          `GPM_TX_PASS_OR:  b = |(rx_pass_in & map);
          `GPM_TX_FV:       b = tx_frame_valid_in[t];
          `GPM_TX_LV:       b = tx_line_valid_in[t];
          `GPM_TX_SYNC:     b = tx_synced_in[t];
          `GPM_TX_INTR:     b = tx_interrupt_in[t];
          default:          b = 1'b0;                 // reserved codes
        endcase
      end
      assign tx_bit[t] = b;
    end
  endgenerate

  // device-wide combined indications
  always @* begin
    case (sig_sel)
      `GPM_DEV_LOCK_OR:  dev_bit = |(rx_lock_in & rx_port_enable_in);
      `GPM_DEV_LOCK_AND: dev_bit = &(rx_lock_in | ~rx_port_enable_in);
      `GPM_DEV_PASS_AND: dev_bit = &(rx_pass_in | ~rx_port_enable_in);
      `GPM_DEV_FSYNC:    dev_bit = frame_sync_signal_in;
      default:           dev_bit = 1'b0;
    endcase
  end

  // source selection
  always @* begin
    case (src_sel)
      3'h0, 3'h1, 3'h2, 3'h3: mux_bit = rx_bit[src_sel[1:0]];
      `GPM_SRC_STATUS:        mux_bit = dev_bit;
      3'h6:                   mux_bit = tx_bit[0];
      3'h7:                   mux_bit = tx_bit[1];
      default:                mux_bit = 1'b0;                 // reserved source
    endcase
  end

  // pin driver, registered; enable low while driving
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      pin_q  <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      pin_q  <= local_mode_q ? ctrl_q[`GPM_VAL_BIT] : mux_bit;
      oe_n_q <= ~ctrl_q[`GPM_EN_BIT];
    end
  end

  assign pin5_out      = pin_q;
  assign pin5_oe_n_out = oe_n_q;

  // write channel: address and data taken in either order
  wire aw_fire = s_axi_awvalid_in & ~aw_got_q & ~bvalid_q;
  wire w_fire  = s_axi_wvalid_in & ~w_got_q & ~bvalid_q;
  wire aw_now  = aw_got_q | aw_fire;
  wire w_now   = w_got_q | w_fire;
  wire [7:0]  wa = aw_got_q ? aw_addr_q : s_axi_awaddr_in;
  wire [31:0] wd = w_got_q ? w_data_q : s_axi_wdata_in;
  wire        ws = w_got_q ? w_strb0_q : s_axi_wstrb_in[0];
  wire do_wr   = aw_now & w_now & ~bvalid_q;

  assign s_axi_awready_out = ~aw_got_q & ~bvalid_q;
  assign s_axi_wready_out  = ~w_got_q & ~bvalid_q;
  assign s_axi_bvalid_out  = bvalid_q;
  assign s_axi_bresp_out   = bresp_q;

  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      aw_got_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_got_q      <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      w_strb0_q    <= 1'b0;
      bvalid_q     <= 1'b0;
      bresp_q      <= `GPM_RESP_OKAY;
      ctrl_q       <= `GPM_CTRL_RESET;
      local_mode_q <= `GPM_MODE_RESET;
    end else begin
      if (aw_fire) begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= s_axi_awaddr_in;
      end
      if (w_fire) begin
        w_got_q   <= 1'b1;
        w_data_q  <= s_axi_wdata_in;
        w_strb0_q <= s_axi_wstrb_in[0];
      end
      if (do_wr) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= `GPM_RESP_OKAY;
        // word address compared at full byte width, low bits ignored
        case ({wa[7:2], 2'b00})
          `GPM_CTRL_ADDR: if (ws) ctrl_q <= wd[7:0];
          `GPM_MODE_ADDR: if (ws) local_mode_q <= wd[0];
          `GPM_STAT_ADDR: bresp_q <= `GPM_RESP_OKAY;      // read-only, ignored
          default:             bresp_q <= `GPM_RESP_SLVERR;
        endcase
      end else if (bvalid_q && s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel: one read at a time, answer one cycle after address
  assign s_axi_arready_out = ~rvalid_q;
  assign s_axi_rvalid_out  = rvalid_q;
  assign s_axi_rdata_out   = rdata_q;
  assign s_axi_rresp_out   = rresp_q;

  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `GPM_RESP_OKAY;
    end else if (s_axi_arvalid_in && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `GPM_RESP_OKAY;
      case ({s_axi_araddr_in[7:2], 2'b00})
        `GPM_CTRL_ADDR: rdata_q <= {24'h00_0000, ctrl_q};
        `GPM_MODE_ADDR: rdata_q <= {31'h0000_0000, local_mode_q};
        `GPM_STAT_ADDR: rdata_q <= {29'h0000_0000, mux_bit, ~oe_n_q, pin_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `GPM_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule // gpm_pin5_output_mux
`default_nettype wire

// ===== tb/gpm_pin_obs.sv
// board-side observer of pin 5: reports the level seen on the pad
// assumes the pad is released whenever the active-low enable is high
`timescale 1ns/1ps
`default_nettype none
module gpm_pin_obs (
  input  wire logic clk_sys_in,
  input  wire logic pin5_in,
  input  wire logic oe_n_in,
  output logic      level_out
);
  logic last_q;
  // remember the last driven level
  always @(posedge clk_sys_in) if (!oe_n_in) last_q <= pin5_in;
  // a released pad shows the inverse, so a stale value never passes
  assign level_out = oe_n_in ? ~last_q : pin5_in;
endmodule // gpm_pin_obs
`default_nettype wire

// ===== tb/gpm_pin5_output_mux_asserts.sv
// checker for the pin 5 multiplexer: reset state and bus handshakes
// assumes it is bound to the design top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module gpm_mux_chk (
  input wire logic        clk_sys_in, srst_in, pin5_out, pin5_oe_n_out,
  input wire logic        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in,
  input wire logic        s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in,
  input wire logic        s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic [1:0]  s_axi_bresp_out, s_axi_rresp_out,
  input wire logic [7:0]  s_axi_araddr_in,
  input wire logic [31:0] s_axi_rdata_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  // read taken, and read taken at an address with no register
  sequence s_rd_take; s_axi_arvalid_in && s_axi_arready_out; endsequence
  sequence s_rd_unmapped;
    s_rd_take ##0 !(s_axi_araddr_in[7:2] inside {6'h15, 6'h20, 6'h21});
  endsequence
  property p_rst;
    disable iff (1'b0) srst_in |=> pin5_oe_n_out && !pin5_out && !s_axi_bvalid_out;
  endproperty
  property p_rd_ans; s_rd_take |=> s_axi_rvalid_out; endproperty
  property p_rd_hold;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  property p_rd_block; s_axi_rvalid_out |-> !s_axi_arready_out; endproperty
  property p_rd_unmapped;
    s_rd_unmapped |=> s_axi_rresp_out == 2'h2 && s_axi_rdata_out == 32'h0;
  endproperty
  property p_wr_ans;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
      |=> s_axi_bvalid_out;
  endproperty
  property p_wr_hold;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  property p_wr_block; s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out;
  endproperty
  a_rst: assert property (p_rst) else $error("pin not released after reset");
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  a_rd_block: assert property (p_rd_block) else $error("read taken while busy");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
  a_wr_hold: assert property (p_wr_hold) else $error("write response dropped");
  a_wr_block: assert property (p_wr_block) else $error("write taken while busy");
endmodule // gpm_mux_chk
bind gpm_pin5_output_mux gpm_mux_chk u_chk (.*);
`default_nettype wire

// ===== tb/gpm_pin5_output_mux_tb.sv
// bench for the pin 5 multiplexer: table of selections, then hand cases
// assumes the defines header on the include path and the observer model
`timescale 1ns/1ps
`default_nettype none
`include "gpm_defines.vh"
module gpm_pin5_output_mux_tb;
  logic        clk_sys_in = 0, srst_in = 1, frame_sync_signal_in = 1;
  logic        s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 1;
  logic        s_axi_arvalid_in = 0, s_axi_rready_in = 1;
  logic [7:0]  s_axi_awaddr_in = 0, s_axi_araddr_in = 0, tx_rx_map_in = 8'h61;
  logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out, rd_q;
  logic [3:0]  s_axi_wstrb_in = 4'hF, rx_lock_in = 4'h5, rx_pass_in = 4'h3;
  logic [3:0]  rx_frame_valid_in = 4'h8, rx_line_valid_in = 4'h4, rx_port_enable_in = 4'h7;
  logic [15:0] rx_remote_gpio_in = 16'h1248;
  logic [1:0]  tx_frame_valid_in = 2'h2, tx_line_valid_in = 2'h1, tx_synced_in = 2'h1;
  logic [1:0]  tx_interrupt_in = 2'h2, s_axi_bresp_out, s_axi_rresp_out, resp;
  logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic        s_axi_rvalid_out, pin5_out, pin5_oe_n_out, seen_level;
  int          failures = 0, num_checks = 0, cycles = 0;
  // rows: mode nibble, control byte, expected pin level in bit 0
  logic [15:0] rows [34] = '{16'h0611, 16'h0650, 16'h0451, 16'h0891, 16'h08D0, 16'h0A11,
    16'h0A90, 16'h0CD1, 16'h0ED0, 16'h0E91, 16'h0111, 16'h0310, 16'h0510, 16'h0711,
    16'h0B10, 16'h0150, 16'h0191, 16'h0391, 16'h0590, 16'h0791, 16'h0991, 16'h0B90,
    16'h0F90, 16'h01D0, 16'h03D1, 16'h05D1, 16'h07D0, 16'h09D0, 16'h0BD1, 16'h1031,
    16'h1010, 16'h0600, 16'h0910, 16'h0D90};
  gpm_pin5_output_mux dut (.*);
  gpm_pin_obs u_obs (.clk_sys_in(clk_sys_in), .pin5_in(pin5_out),
                     .oe_n_in(pin5_oe_n_out), .level_out(seen_level));
  always #10 clk_sys_in = ~clk_sys_in;
  // cut a hang short
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    {ta, tw} = 2'h0;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1;
    s_axi_wvalid_in <= 1;
    while (!(ta && tw)) begin
      @(negedge clk_sys_in);
      ta |= s_axi_awready_out;
      tw |= s_axi_wready_out;
      @(posedge clk_sys_in);
      if (ta) s_axi_awvalid_in <= 0;
      if (tw) s_axi_wvalid_in <= 0;
    end
    do @(negedge clk_sys_in); while (!s_axi_bvalid_out);
    r = s_axi_bresp_out;
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1;
    do @(negedge clk_sys_in); while (!s_axi_arready_out);
    @(posedge clk_sys_in) s_axi_arvalid_in <= 0;
    do @(negedge clk_sys_in); while (!s_axi_rvalid_out);
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
    @(posedge clk_sys_in);
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys_in);
    srst_in <= 0;
    @(posedge clk_sys_in);
    rd(`GPM_CTRL_ADDR, rd_q, resp);
    chk("ctrl_reset", rd_q, 32'(`GPM_CTRL_RESET));
    chk("oe_n_reset", 32'(pin5_oe_n_out), 32'h1);
    foreach (rows[i]) begin
      wr(`GPM_MODE_ADDR, 32'(rows[i][15:12]), resp);
      wr(`GPM_CTRL_ADDR, 32'(rows[i][11:4]), resp);
      repeat (2) @(negedge clk_sys_in);
      chk("oe_n", 32'(pin5_oe_n_out), 32'(!rows[i][4]));
      if (rows[i][4]) chk("pin", 32'(seen_level), 32'(rows[i][0]));
      @(posedge clk_sys_in);
    end
    // unmapped places, both answers held while the master is not ready
    s_axi_bready_in <= 0;
    s_axi_rready_in <= 0;
    wr(8'h10, 32'hFF, resp);
    chk("wr_unmapped", 32'(resp), 32'(`GPM_RESP_SLVERR));
    rd(8'h10, rd_q, resp);
    chk("rd_unmapped", 32'(resp), 32'(`GPM_RESP_SLVERR));
    chk("rd_unmapped_data", rd_q, 32'h0);
    repeat (2) @(negedge clk_sys_in);
    chk("b_held", 32'(s_axi_bvalid_out), 32'h1);
    chk("r_held", 32'(s_axi_rvalid_out), 32'h1);
    @(posedge clk_sys_in);
    s_axi_bready_in <= 1;
    s_axi_rready_in <= 1;
    @(posedge clk_sys_in);
    // status write ignored, strobe-less write, pin following its input
    wr(`GPM_STAT_ADDR, 32'h00, resp);
    chk("wr_status", 32'(resp), 32'(`GPM_RESP_OKAY));
    wr(`GPM_CTRL_ADDR, 32'h81, resp);
    s_axi_wstrb_in <= 4'h0;
    wr(`GPM_CTRL_ADDR, 32'h00, resp);
    s_axi_wstrb_in <= 4'hF;
    rd(`GPM_CTRL_ADDR, rd_q, resp);
    chk("ctrl_kept", rd_q, 32'h81);
    rd(`GPM_STAT_ADDR, rd_q, resp);
    chk("status", rd_q, 32'h7);
    rd(`GPM_MODE_ADDR, rd_q, resp);
    chk("mode", rd_q, 32'h0);
    chk("pin_lock", 32'(seen_level), 32'h1);
    rx_lock_in <= 4'h4;
    repeat (2) @(negedge clk_sys_in);
    chk("pin_follow", 32'(seen_level), 32'h0);
    // second reset in mid-run
    @(posedge clk_sys_in) srst_in <= 1;
    repeat (5) @(posedge clk_sys_in);
    srst_in <= 0;
    @(posedge clk_sys_in);
    rd(`GPM_CTRL_ADDR, rd_q, resp);
    chk("ctrl_rerst", rd_q, 32'(`GPM_CTRL_RESET));
    chk("oe_n_rerst", 32'(pin5_oe_n_out), 32'h1);
    report_and_stop();
  end
endmodule // gpm_pin5_output_mux_tb
`default_nettype wire
